// ### design/gms_sequencer.sv
// Mode and load-transfer sequencer for a generator set controller
`include "gms_cfg.svh"
`default_nettype none
module gms_sequencer (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Front-panel buttons and digital inputs
  input  wire logic                      btn_stop_i,
  input  wire logic                      btn_manual_i,
  input  wire logic                      btn_auto_i,
  input  wire logic                      btn_start_i,
  input  wire logic                      btn_take_load_i,
  input  wire logic                      btn_open_i,
  input  wire logic                      din_take_load_i,
  input  wire logic                      din_open_i,
  input  wire logic                      din_on_load_i,
  // Remote requests and plant feedback
  input  wire logic [7:0]                multiset_link_req_i,
  input  wire logic                      gen_available_i,
  input  wire logic                      in_sync_i,
  input  wire logic                      ramp_done_i,
  input  wire logic [`GMS_ALARM_W-1:0]   alarm_cond_i,
  // Plant outputs
  output logic                           engine_run_o,
  output logic                           gen_close_o,
  output logic                           sync_req_o,
  output logic                           ramp_down_o,
  output logic [1:0]                     mode_o,
  output logic [`GMS_ALARM_W-1:0]        alarm_latch_o,
  // Register port
  input  wire logic [3:0]                reg_addr_i,
  input  wire logic [31:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic [31:0]                    reg_rdata_o,
  output logic                           irq_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Bit positions of each pin inside the packed synchroniser vector
  localparam int POS_RAMP   = 0;
  localparam int POS_SYNC   = 1;
  localparam int POS_AVAIL  = 2;
  localparam int POS_ONLOAD = 3;
  localparam int POS_DOPEN  = 4;
  localparam int POS_DTAKE  = 5;
  localparam int POS_BOPEN  = 6;
  localparam int POS_BTAKE  = 7;
  localparam int POS_START  = 8;
  localparam int POS_AUTO   = 9;
  localparam int POS_MANUAL = 10;
  localparam int POS_STOP   = 11;
  localparam int POS_LINK   = 12;
  localparam int POS_ALARM  = 20;

  // Pins come from the panel and plant, so every one passes two flops
  localparam int NPIN = POS_ALARM + `GMS_ALARM_W;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m_q;
  logic [NPIN-1:0] pin_s_q;
  logic [NPIN-1:0] pin_p_q;

  assign pin_raw = {alarm_cond_i, multiset_link_req_i, btn_stop_i, btn_manual_i, btn_auto_i,
                    btn_start_i, btn_take_load_i, btn_open_i, din_take_load_i, din_open_i,
                    din_on_load_i, gen_available_i, in_sync_i, ramp_done_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      pin_p_q <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end

  // Rising edge of a synchronised level: one pulse per press
  // Last stage resets low, the idle level of every pin, so reset gives no false press
  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  logic [`GMS_ALARM_W-1:0] alarm_s;
  logic                    link_req;
  logic                    stop_p;
  logic                    manual_p;
  logic                    auto_p;
  logic                    start_p;
  logic                    take_p;
  logic                    open_p;
  logic                    on_load_s;
  logic                    avail_s;
  logic                    sync_s;
  logic                    ramp_s;

  assign alarm_s   = pin_s_q[POS_ALARM +: `GMS_ALARM_W];
  assign link_req  = |pin_s_q[POS_LINK +: 8];
  assign stop_p    = rise(pin_s_q[POS_STOP], pin_p_q[POS_STOP]);
  assign manual_p  = rise(pin_s_q[POS_MANUAL], pin_p_q[POS_MANUAL]);
  assign auto_p    = rise(pin_s_q[POS_AUTO], pin_p_q[POS_AUTO]);
  assign start_p   = rise(pin_s_q[POS_START], pin_p_q[POS_START]);
  // [R07] Inputs equal buttons
  assign take_p    = rise(pin_s_q[POS_BTAKE], pin_p_q[POS_BTAKE]) | rise(pin_s_q[POS_DTAKE], pin_p_q[POS_DTAKE]);
  assign open_p    = rise(pin_s_q[POS_BOPEN], pin_p_q[POS_BOPEN]) | rise(pin_s_q[POS_DOPEN], pin_p_q[POS_DOPEN]);
  assign on_load_s = pin_s_q[POS_ONLOAD];
  assign avail_s   = pin_s_q[POS_AVAIL];
  assign sync_s    = pin_s_q[POS_SYNC];
  assign ramp_s    = pin_s_q[POS_RAMP];

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  gms_pkg::gms_mode_t mode_q;
  logic               mode_chg;

  // [R16] Button overrides mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= gms_pkg::GMS_MODE_STOP;
    end else if (stop_p) begin
      mode_q <= gms_pkg::GMS_MODE_STOP;
    end else if (manual_p) begin
      mode_q <= gms_pkg::GMS_MODE_MANUAL;
    end else if (auto_p) begin
      mode_q <= gms_pkg::GMS_MODE_AUTO;
    end
  end

  // Stop wins when several buttons rise together
  assign mode_chg = stop_p | manual_p | auto_p;

  // ----------------------------------------------------------------
  // Alarm latches
  // ----------------------------------------------------------------
  // [R01] Clear gone alarms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_latch_o <= '0;
    end else if (stop_p) begin
      alarm_latch_o <= alarm_s;
    end else begin
      alarm_latch_o <= alarm_latch_o | alarm_s;
    end
  end

  // ----------------------------------------------------------------
  // Load sequence
  // ----------------------------------------------------------------
  gms_pkg::gms_state_t st_q;
  logic [`GMS_TMR_W-1:0] tmr_q;
  logic [`GMS_TMR_W-1:0] ret_dly_q;
  logic [`GMS_TMR_W-1:0] cool_dly_q;
  logic                  tmr_done;
  logic                  manual_st;
  logic                  auto_st;
  logic                  entering;
  logic [2:0]            st_prev_q;

  // A timed state sees a stale zero in its first cycle, so done waits for the load
  assign tmr_done  = (tmr_q == '0) && !entering;
  assign manual_st = (mode_q == gms_pkg::GMS_MODE_MANUAL) && !mode_chg;
  assign auto_st   = (mode_q == gms_pkg::GMS_MODE_AUTO) && !mode_chg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= gms_pkg::GMS_ST_IDLE;
    end else if (stop_p) begin
      // [R03] Stop holds rest
      st_q <= gms_pkg::GMS_ST_IDLE;
    end else if (manual_p) begin
      // Running set stays running and an ON_LOAD set stays on load; the other load states resume off load
      st_q <= (st_q == gms_pkg::GMS_ST_ON_LOAD) ? gms_pkg::GMS_ST_ON_LOAD :
              (st_q == gms_pkg::GMS_ST_IDLE) ? gms_pkg::GMS_ST_IDLE : gms_pkg::GMS_ST_RUN_OFF;
    end else if (auto_p) begin
      // Auto takes over a running set; removal of request path then applies
      st_q <= (st_q == gms_pkg::GMS_ST_IDLE) ? gms_pkg::GMS_ST_IDLE : gms_pkg::GMS_ST_RUN_OFF;
    end else if (mode_q == gms_pkg::GMS_MODE_STOP) begin
      st_q <= gms_pkg::GMS_ST_IDLE;
    end else if (manual_st) begin
      case (st_q)
        // [R04] Manual start
        gms_pkg::GMS_ST_IDLE: begin
          if (start_p) st_q <= gms_pkg::GMS_ST_RUN_OFF;
        end
        // [R08] On-load input
        gms_pkg::GMS_ST_RUN_OFF: begin
          if ((take_p || on_load_s) && avail_s) st_q <= gms_pkg::GMS_ST_SYNC;
        end
        // [R05] Close after sync
        gms_pkg::GMS_ST_SYNC: begin
          if (open_p) st_q <= gms_pkg::GMS_ST_RUN_OFF;
          else if (sync_s) st_q <= gms_pkg::GMS_ST_ON_LOAD;
        end
        // [R09] Hold close
        gms_pkg::GMS_ST_ON_LOAD: begin
          if (open_p) st_q <= gms_pkg::GMS_ST_RAMP;
        end
        // [R06] Ramp then open
        gms_pkg::GMS_ST_RAMP: begin
          if (ramp_s) st_q <= gms_pkg::GMS_ST_RUN_OFF;
        end
        default:                 st_q <= gms_pkg::GMS_ST_RUN_OFF;
      endcase
    end else if (auto_st) begin
      // [R10] Auto ignores operator
      case (st_q)
        // [R11] Link start
        gms_pkg::GMS_ST_IDLE: begin
          if (link_req) st_q <= gms_pkg::GMS_ST_RUN_OFF;
        end
        // [R12] Sync when available
        gms_pkg::GMS_ST_RUN_OFF: begin
          if (!link_req) st_q <= gms_pkg::GMS_ST_COOL;
          else if (avail_s) st_q <= gms_pkg::GMS_ST_SYNC;
        end
        gms_pkg::GMS_ST_SYNC: begin
          if (!link_req) st_q <= gms_pkg::GMS_ST_COOL;
          else if (sync_s) st_q <= gms_pkg::GMS_ST_ON_LOAD;
        end
        // [R13] Return delay
        gms_pkg::GMS_ST_ON_LOAD: begin
          if (!link_req) st_q <= gms_pkg::GMS_ST_RET_DLY;
        end
        gms_pkg::GMS_ST_RET_DLY: begin
          if (link_req) st_q <= gms_pkg::GMS_ST_ON_LOAD;
          else if (tmr_done) st_q <= gms_pkg::GMS_ST_RAMP;
        end
        gms_pkg::GMS_ST_RAMP: begin
          if (ramp_s) st_q <= gms_pkg::GMS_ST_COOL;
        end
        // [R14] Cooling then stop
        gms_pkg::GMS_ST_COOL: begin
          if (link_req) st_q <= gms_pkg::GMS_ST_RUN_OFF;
          // [R15] Back to idle
          else if (tmr_done) st_q <= gms_pkg::GMS_ST_IDLE;
        end
        default:                 st_q <= gms_pkg::GMS_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Delay timer
  // ----------------------------------------------------------------
  // Timer loads on entry to a timed state, then counts down to zero in whatever state follows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_prev_q <= 3'h0;
    end else begin
      st_prev_q <= st_q;
    end
  end
  assign entering = (st_prev_q != st_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_q <= '0;
    end else if (entering && st_q == gms_pkg::GMS_ST_RET_DLY) begin
      tmr_q <= ret_dly_q;
    end else if (entering && st_q == gms_pkg::GMS_ST_COOL) begin
      tmr_q <= cool_dly_q;
    end else if (!tmr_done && !entering) begin
      tmr_q <= tmr_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Plant outputs
  // ----------------------------------------------------------------
  // Outputs drop in the stop press cycle itself, one edge ahead of the mode
  logic active_mode;
  assign active_mode = (mode_q != gms_pkg::GMS_MODE_STOP) && !stop_p;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      engine_run_o <= 1'b0;
      gen_close_o  <= 1'b0;
      sync_req_o   <= 1'b0;
      ramp_down_o  <= 1'b0;
      mode_o       <= 2'b00;
    end else begin
      // [R02] Stop opens close
      engine_run_o <= (st_q != gms_pkg::GMS_ST_IDLE) && active_mode;
      gen_close_o  <= (st_q == gms_pkg::GMS_ST_ON_LOAD || st_q == gms_pkg::GMS_ST_RET_DLY ||
                       st_q == gms_pkg::GMS_ST_RAMP) && active_mode;
      sync_req_o   <= (st_q == gms_pkg::GMS_ST_SYNC) && active_mode;
      ramp_down_o  <= (st_q == gms_pkg::GMS_ST_RAMP) && active_mode;
      mode_o       <= mode_q;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  logic [`GMS_IRQ_W-1:0] evt;
  logic [`GMS_IRQ_W-1:0] irq_stat_q;
  logic [`GMS_IRQ_W-1:0] irq_mask_q;
  logic                  close_prev_q;
  logic                  run_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      close_prev_q <= 1'b0;
      run_prev_q   <= 1'b0;
    end else begin
      close_prev_q <= gen_close_o;
      run_prev_q   <= engine_run_o;
    end
  end

  assign evt[`GMS_IRQ_MODE]    = mode_chg;
  assign evt[`GMS_IRQ_CLOSED]  = rise(gen_close_o, close_prev_q);
  assign evt[`GMS_IRQ_OPENED]  = rise(close_prev_q, gen_close_o);
  assign evt[`GMS_IRQ_STOPPED] = rise(run_prev_q, engine_run_o);

  // A new event in the clearing read's cycle survives the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else if (reg_rd_i && reg_addr_i == `GMS_REG_IRQ_STAT) begin
      irq_stat_q <= evt;
    end else begin
      irq_stat_q <= irq_stat_q | evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= `GMS_IRQ_MASK_RST;
      ret_dly_q  <= `GMS_RET_DLY_RST;
      cool_dly_q <= `GMS_COOL_DLY_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `GMS_REG_IRQ_MASK: irq_mask_q <= reg_wdata_i[`GMS_IRQ_W-1:0];
        `GMS_REG_RET_DLY:  ret_dly_q  <= reg_wdata_i;
        `GMS_REG_COOL_DLY: cool_dly_q <= reg_wdata_i;
        default:           ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `GMS_REG_MODE:     reg_rdata_o <= {30'h0, mode_q};
        `GMS_REG_STATUS:   reg_rdata_o <= {25'h0, st_q, engine_run_o, gen_close_o, sync_req_o, ramp_down_o};
        `GMS_REG_IRQ_STAT: reg_rdata_o <= {28'h000_0000, irq_stat_q};
        `GMS_REG_IRQ_MASK: reg_rdata_o <= {28'h000_0000, irq_mask_q};
        `GMS_REG_RET_DLY:  reg_rdata_o <= ret_dly_q;
        `GMS_REG_COOL_DLY: reg_rdata_o <= cool_dly_q;
        `GMS_REG_ALARM:    reg_rdata_o <= {24'h00_0000, alarm_latch_o};
        default:           reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ### design/gms_cfg.svh
// Constants of the genset mode sequencer: register offsets, fields, reset values, timer counts
//
// Notes on behaviour
// [R01] Stop/reset clears alarms whose cause has gone
// [R02] Stop/reset with engine running opens close output
// [R03] Stop/reset keeps generator at rest, no start
// [R04] Manual start runs generator off load
// [R05] Manual take-load synchronises, then closes
// [R06] Manual open ramps load off, then opens
// [R07] Digital inputs act like the buttons
// [R08] Manual on-load input synchronises then closes
// [R09] Manual close holds until stop or auto
// [R10] Auto runs on requests and timers only
// [R11] Auto starts on any multiset link request
// [R12] Auto synchronises and closes once available
// [R13] Auto request removal: return delay, ramp, open
// [R14] Auto cooling period after open, then stop
// [R15] Auto returns idle awaiting next request
// [R16] Exactly one mode; buttons override at once
`ifndef GMS_CFG_SVH
`define GMS_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define GMS_REG_MODE      4'h0
`define GMS_REG_STATUS    4'h1
`define GMS_REG_IRQ_STAT  4'h2
`define GMS_REG_IRQ_MASK  4'h3
`define GMS_REG_RET_DLY   4'h4
`define GMS_REG_COOL_DLY  4'h5
`define GMS_REG_ALARM     4'h6

// ----------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------
`define GMS_IRQ_MODE      0
`define GMS_IRQ_CLOSED    1
`define GMS_IRQ_OPENED    2
`define GMS_IRQ_STOPPED   3
`define GMS_IRQ_W         4

// ----------------------------------------------------------------
// Reset values and timers
// ----------------------------------------------------------------
`define GMS_ALARM_W       8
`define GMS_TMR_W         32
`define GMS_IRQ_MASK_RST  4'h0
`define GMS_RET_DLY_RST   32'h0000_00ff
`define GMS_COOL_DLY_RST  32'h0000_00ff

`endif

// ### design/gms_pkg.sv
// Types of the genset mode sequencer
`default_nettype none
package gms_pkg;
  typedef enum logic [1:0] {
    GMS_MODE_STOP   = 2'b00,
    GMS_MODE_MANUAL = 2'b01,
    GMS_MODE_AUTO   = 2'b10
  } gms_mode_t;

  typedef enum logic [2:0] {
    GMS_ST_IDLE     = 3'b000,
    GMS_ST_RUN_OFF  = 3'b001,
    GMS_ST_SYNC     = 3'b010,
    GMS_ST_ON_LOAD  = 3'b011,
    GMS_ST_RET_DLY  = 3'b100,
    GMS_ST_RAMP     = 3'b101,
    GMS_ST_COOL     = 3'b110
  } gms_state_t;
endpackage
`default_nettype wire

// ### tb/gms_asserts.sv
// Port-level checker for the genset mode sequencer
`default_nettype none
module gms_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        reg_rd_i,
  input wire logic        engine_run_o,
  input wire logic        gen_close_o,
  input wire logic        sync_req_o,
  input wire logic        ramp_down_o,
  input wire logic [1:0]  mode_o,
  input wire logic [31:0] reg_rdata_o
);
  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_mode_legal: assert property (
    mode_o != 2'b11) else $error("mode code outside the three modes");
  // Three cycles of stop give the outputs two edges to drop
  a_stop_rest: assert property (
    (mode_o == 2'b00 && $past(mode_o) == 2'b00 && $past(mode_o, 2) == 2'b00) |-> !engine_run_o && !sync_req_o)
    else $error("engine or sync active in stop mode");
  a_stop_open: assert property (
    (mode_o == 2'b00 && $past(mode_o) == 2'b00 && $past(mode_o, 2) == 2'b00) |-> !gen_close_o && !ramp_down_o)
    else $error("close or ramp active in stop mode");
  a_close_sync: assert property (
    $rose(gen_close_o) |-> $past(sync_req_o)) else $error("close rose without a sync request");
  // On a stop press the mode output lags the plant outputs by one edge, so the next cycle must show no mode change
  a_open_ramp: assert property (
    ($fell(gen_close_o) && mode_o != 2'b00 && mode_o == $past(mode_o) && mode_o == $past(mode_o, 2))
    ##1 (mode_o == $past(mode_o)) |-> $past(ramp_down_o, 2)) else $error("close fell without a ramp down");
  a_close_running: assert property (
    gen_close_o |-> engine_run_o) else $error("close active with engine stopped");
  a_sync_running: assert property (
    sync_req_o |-> engine_run_o) else $error("sync request with engine stopped");
  // Bench programs a cooling time of at least four cycles
  a_cool_hold: assert property (
    (($fell(gen_close_o) && mode_o == 2'b10 && $past(mode_o) == 2'b10) ##1 (mode_o == 2'b10))
    |-> engine_run_o [*4])
    else $error("engine stopped before cooling");
  a_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data outside its cycle");
endmodule

bind gms_sequencer gms_asserts gms_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i), .engine_run_o(engine_run_o), .gen_close_o(gen_close_o),
  .sync_req_o(sync_req_o), .ramp_down_o(ramp_down_o), .mode_o(mode_o), .reg_rdata_o(reg_rdata_o));
`default_nettype wire

// ### tb/gms_plant.sv
// Behavioural engine and switchgear feedback model
`default_nettype none
module gms_plant (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  input  wire logic engine_run_i,
  input  wire logic sync_req_i,
  input  wire logic ramp_down_i,
  output logic      gen_available_o,
  output logic      in_sync_o,
  output logic      ramp_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] lim;
  logic [5:0] run_q;
  logic [5:0] sync_q;
  logic [5:0] ramp_q;
  // Slow mode stretches every plant response well past the input filters
  assign lim = slow_i ? 6'h28 : 6'h03;
  always @(posedge clk_i) begin
    run_q <= (rst_i || !engine_run_i) ? 6'h00 : (run_q < lim) ? run_q + 6'h01 : run_q;
    sync_q <= (rst_i || !sync_req_i) ? 6'h00 : (sync_q < lim) ? sync_q + 6'h01 : sync_q;
    ramp_q <= (rst_i || !ramp_down_i) ? 6'h00 : (ramp_q < lim) ? ramp_q + 6'h01 : ramp_q;
  end
  assign gen_available_o = engine_run_i && run_q >= lim;
  // Synchronism and ramp completion only while the request stands
  assign in_sync_o       = sync_req_i && sync_q >= lim;
  assign ramp_done_o     = ramp_down_i && ramp_q >= lim;
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the genset mode sequencer
`include "gms_cfg.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, slow, on_load, reg_wr, reg_rd;
  logic [7:0]  pb, link, alarm, alarm_latch;
  logic [3:0]  reg_addr, outs;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [1:0]  mode;
  logic        run, close, sync, ramp, irq, avail, insync, rdone;
  int          bad_count, checks_done, n;

  assign outs = {ramp, sync, close, run};

  gms_sequencer gms_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .btn_stop_i(pb[0]), .btn_manual_i(pb[1]), .btn_auto_i(pb[2]),
    .btn_start_i(pb[3]), .btn_take_load_i(pb[4]), .btn_open_i(pb[5]), .din_take_load_i(pb[6]),
    .din_open_i(pb[7]), .din_on_load_i(on_load), .multiset_link_req_i(link), .gen_available_i(avail),
    .in_sync_i(insync), .ramp_done_i(rdone), .alarm_cond_i(alarm), .engine_run_o(run), .gen_close_o(close),
    .sync_req_o(sync), .ramp_down_o(ramp), .mode_o(mode), .alarm_latch_o(alarm_latch), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_o(irq));

  gms_plant gms_plant_inst (
    .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .engine_run_i(run), .sync_req_i(sync),
    .ramp_down_i(ramp), .gen_available_o(avail), .in_sync_o(insync), .ramp_done_o(rdone));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Outputs are sampled just after the edge so their updates have landed
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask

  task automatic press(input int k);
    @(posedge clk_i);
    pb[k] <= 1'b1;
    repeat (4) @(posedge clk_i);
    pb[k] <= 1'b0;
    settle(8);
  endtask

  task automatic wait_out(input int k, input logic lvl, output int c);
    c = 0;
    while (outs[k] !== lvl) begin
      settle(1);
      c++;
      if (c > 400) begin
        chk("wait_timeout", 32'h1, 32'h0);
        end_of_test;
      end
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_i);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_i);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chkr(input logic [3:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, slow, on_load, reg_wr, reg_rd} = 5'b10000;
    {pb, link, alarm, reg_addr, reg_wdata} = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(4);
    chkr(`GMS_REG_IRQ_MASK, 32'h0, "irq_mask_rst");
    chkr(`GMS_REG_RET_DLY, `GMS_RET_DLY_RST, "ret_dly_rst");
    chkr(`GMS_REG_COOL_DLY, `GMS_COOL_DLY_RST, "cool_dly_rst");
    chkr(4'hf, 32'h0, "unmapped");
    wr(`GMS_REG_MODE, 32'h1);
    chkr(`GMS_REG_MODE, 32'h0, "mode_read_only");
    wr(`GMS_REG_RET_DLY, 32'h6);
    wr(`GMS_REG_COOL_DLY, 32'h8);
    wr(`GMS_REG_IRQ_MASK, 32'hf);
    rd(`GMS_REG_IRQ_STAT, v);
    press(3);
    chk("run_in_stop", run, 1'b0);
    press(1);
    chk("mode_manual", mode, 2'b01);
    chk("irq_mode", irq, 1'b1);
    chkr(`GMS_REG_IRQ_STAT, 32'h1, "irq_stat_mode");
    settle(3);
    chk("irq_cleared", irq, 1'b0);
    press(3);
    chk("manual_run", {run, close}, 2'b10);
    // Slow plant so sync and ramp outlast a press; wait until the set is available
    slow = 1'b1;
    settle(48);
    press(4);
    wait_out(2, 1'b1, n);
    chk("sync_before_close", close, 1'b0);
    wait_out(1, 1'b1, n);
    press(7);
    wait_out(3, 1'b1, n);
    chk("ramp_before_open", close, 1'b1);
    wait_out(1, 1'b0, n);
    slow = 1'b0;
    press(6);
    wait_out(1, 1'b1, n);
    chk("din_take_load", sync, 1'b0);
    press(5);
    wait_out(1, 1'b0, n);
    @(posedge clk_i);
    on_load <= 1'b1;
    wait_out(1, 1'b1, n);
    @(posedge clk_i);
    on_load <= 1'b0;
    settle(30);
    chk("close_holds", close, 1'b1);
    @(posedge clk_i);
    alarm <= 8'h05;
    settle(6);
    @(posedge clk_i);
    alarm <= 8'h04;
    press(0);
    chk("stop_offload", {mode, run, close}, 4'h0);
    chk("alarm_kept", alarm_latch, 8'h04);
    press(2);
    press(3);
    press(4);
    chk("auto_no_panel", {mode, run}, 3'b100);
    @(posedge clk_i);
    link <= 8'h20;
    wait_out(0, 1'b1, n);
    wait_out(1, 1'b1, n);
    chk("auto_closed", sync, 1'b0);
    wr(`GMS_REG_IRQ_MASK, 32'h0);
    settle(3);
    chk("irq_masked", irq, 1'b0);
    wr(`GMS_REG_IRQ_MASK, 32'h2);
    settle(3);
    chk("irq_unmasked", irq, 1'b1);
    rd(`GMS_REG_IRQ_STAT, v);
    chk("irq_stat_close", v & 32'h2, 32'h2);
    @(posedge clk_i);
    link <= 8'h00;
    wait_out(3, 1'b1, n);
    chk("return_delay", n >= 6, 1'b1);
    chk("irq_after_read", irq, 1'b0);
    wait_out(1, 1'b0, n);
    wait_out(0, 1'b0, n);
    chk("cooling_time", n >= 8, 1'b1);
    @(posedge clk_i);
    link <= 8'h01;
    wait_out(0, 1'b1, n);
    chk("auto_restart", mode, 2'b10);
    press(0);
    chk("stop_again", run, 1'b0);
    end_of_test;
  end
endmodule
`default_nettype wire
